//--- rtl/mrd_pkg.sv
// constants for the mode-dependent register defaults block
package mrd_pkg;

	// ***************************************************
	// register indices (byte address is four times these)
	// ***************************************************
	localparam logic [6:0] IX_WDCTRL = 7'h00;
	localparam logic [6:0] IX_MODE   = 7'h01;
	localparam logic [6:0] IX_MSTAT  = 7'h03;
	localparam logic [6:0] IX_SEVEN  = 7'h04;
	localparam logic [6:0] IX_WDSTAT = 7'h05;
	localparam logic [6:0] IX_SCR0   = 7'h06;
	localparam logic [6:0] IX_SCR3   = 7'h09;
	localparam logic [6:0] IX_LOCK   = 7'h0A;
	localparam logic [6:0] IX_SUPCTL = 7'h10;
	localparam logic [6:0] IX_SUPST  = 7'h1B;
	localparam logic [6:0] IX_TRXST  = 7'h22;
	localparam logic [6:0] IX_TRXEN  = 7'h23;
	localparam logic [6:0] IX_GEVT   = 7'h60;
	localparam logic [6:0] IX_SEVT   = 7'h61;
	localparam logic [6:0] IX_NVMST  = 7'h70;
	localparam logic [6:0] IX_START  = 7'h73;
	localparam logic [6:0] IX_CFG    = 7'h74;
	localparam logic [6:0] IX_IDENT  = 7'h7E;

	// ***************************************************
	// field positions
	// ***************************************************
	localparam int P_WMC   = 5;
	localparam int P_OVERTEMP_WARN_STATUS  = 6;
	localparam int P_NMS   = 5;
	localparam int P_OTW   = 2;
	localparam int P_SERIAL_FAIL_EVENT  = 1;
	localparam int P_WDF   = 0;
	localparam int P_PO    = 4;
	localparam int P_SYSTEM_EVENT_SUMMARY  = 0;
	localparam int P_EXTC  = 2;
	localparam int P_FNM   = 3;
	localparam int P_SDM   = 2;
	localparam int P_VCS   = 1;
	localparam int P_RLC   = 4;
	localparam int P_V1SU  = 4;

	// ***************************************************
	// forced codes and reset values
	// ***************************************************
	localparam logic [2:0] MC_STBY   = 3'h4;
	localparam logic [2:0] MC_NORM   = 3'h7;
	localparam logic [2:0] MC_SLEEP  = 3'h1;
	localparam logic [3:0] NWP_DFLT  = 4'h4;
	localparam logic [4:0] RSS_PON   = 5'h00;
	localparam logic [4:0] RSS_OVT   = 5'h12;
	localparam logic [2:0] WMC_SWDEV = 3'h1;
	localparam logic [2:0] WMC_DFLT  = 3'h2;

	// mode request codes on the mode change port
	localparam logic [2:0] MS_STBY  = 3'h1;
	localparam logic [2:0] MS_NORM  = 3'h2;
	localparam logic [2:0] MS_SLEEP = 3'h3;
	localparam logic [2:0] MS_OVT   = 3'h4;
	localparam logic [2:0] MS_RST   = 3'h5;

	// bus responses
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [5:0] {
		ST_OFF   = 6'b000001,
		ST_STBY  = 6'b000010,
		ST_NORM  = 6'b000100,
		ST_SLEEP = 6'b001000,
		ST_OVT   = 6'b010000,
		ST_RST   = 6'b100000
	} mrd_state_t;

endpackage : mrd_pkg

//--- rtl/mrd_field.sv
// one control field with power-on, mode-event and software loads
`timescale 1ns/1ps
module mrd_field
	import mrd_pkg::*;
#(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         mclk_in,
	input  wire logic         arst_n_in,
	input  wire logic         por_ld_in,
	input  wire logic [W-1:0] por_val_in,
	input  wire logic         evt_ld_in,
	input  wire logic [W-1:0] evt_val_in,
	input  wire logic         sw_we_in,
	input  wire logic [W-1:0] sw_val_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] q_nxt;

	// power-on beats mode event beats software
	always_comb begin
		q_nxt = q_out;
		if (por_ld_in) begin
			q_nxt = por_val_in;
		end else if (evt_ld_in) begin
			q_nxt = evt_val_in;
		end else if (sw_we_in) begin
			q_nxt = sw_val_in;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_out <= RST;
		end else begin
			q_out <= q_nxt;
		end
	end

endmodule : mrd_field

//--- rtl/mrd_bank.sv
// mode-dependent register bank with an AXI4-Lite register port
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module mrd_bank
	import mrd_pkg::*;
#(
	parameter int         AW         = 12,
	parameter logic [7:0] PART_IDENT = 8'h5A // arbitrary value
) (
	input  wire logic          mclk_in,
	input  wire logic          arst_n_in,
	input  wire logic [AW-1:0] s_awaddr_in,
	input  wire logic          s_awvalid_in,
	output logic               s_awready_out,
	input  wire logic [31:0]   s_wdata_in,
	input  wire logic [3:0]    s_wstrb_in,
	input  wire logic          s_wvalid_in,
	output logic               s_wready_out,
	output logic [1:0]         s_bresp_out,
	output logic               s_bvalid_out,
	input  wire logic          s_bready_in,
	input  wire logic [AW-1:0] s_araddr_in,
	input  wire logic          s_arvalid_in,
	output logic               s_arready_out,
	output logic [31:0]        s_rdata_out,
	output logic [1:0]         s_rresp_out,
	output logic               s_rvalid_out,
	input  wire logic          s_rready_in,
	input  wire logic          mode_enter_in,
	input  wire logic [2:0]    mode_sel_in,
	input  wire logic [4:0]    reset_cause_in,
	input  wire logic          forced_normal_config_in,
	input  wire logic [1:0]    reset_length_config_in,
	input  wire logic          sw_dev_config_in,
	input  wire logic          sleep_ctrl_config_in,
	input  wire logic [1:0]    reg_thresh_startup_in,
	input  wire logic [1:0]    ext_supply_startup_in,
	input  wire logic          nvm_checksum_status_in,
	input  wire logic          nvm_programmed_status_in,
	input  wire logic [5:0]    nvm_write_count_status_in,
	input  wire logic [8:0]    live_status_in,
	input  wire logic          wd_fail_in,
	input  wire logic          serial_fail_in,
	input  wire logic          overtemp_warn_in,
	output logic [5:0]         mode_state_out,
	output logic [2:0]         op_mode_ctrl_out,
	output logic [2:0]         wd_mode_ctrl_out,
	output logic [3:0]         wd_nominal_period_out,
	output logic [1:0]         reg_thresh_ctrl_out,
	output logic [1:0]         ext_supply_ctrl_out,
	output logic               can_wake_enable_out
);

	// ***************************************************
	// declarations
	// ***************************************************
	mrd_state_t     state_r, state_nxt;
	logic           por_pend_r;
	logic           evt, e_stby, e_norm, e_sleep, e_ovt, e_rst;
	logic [4:0]     rss_q;
	logic           nms_r, nms_nxt;
	logic [8:0]     st_r, st_nxt;
	logic [31:0]    scr_r, scr_nxt;
	logic [6:0]     lock_r, lock_nxt;
	logic [2:0]     en_r, en_nxt;
	logic           wdf_r, serial_fail_event_r, otw_r, po_r, system_event_summary_r;
	logic           wdf_nxt, serial_fail_event_nxt, otw_nxt, po_nxt, system_event_summary_nxt;
	logic [AW-1:0]  aw_addr_r, aw_addr_nxt;
	logic [7:0]     wd_r, wd_nxt;
	logic           aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic           w_lane_r, w_lane_nxt;
	logic           bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]     bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]    rdata_r, rdata_nxt;
	logic [6:0]     wr_idx, rd_idx;
	logic           wr_go, wr_hit, rd_hit, lock_blk, commit;
	logic [7:0]     rd_byte;
	logic           we_wdc, we_mode, we_sev, we_lock, we_sup, we_trx;
	logic           we_gevt, we_sevt, we_scr;

	// ***************************************************
	// mode change decode
	// ***************************************************
	// events are only acted on once the power-on loads are done
	assign evt     = mode_enter_in & ~por_pend_r;
	assign e_stby  = evt & (mode_sel_in == MS_STBY);
	assign e_norm  = evt & (mode_sel_in == MS_NORM);
	assign e_sleep = evt & (mode_sel_in == MS_SLEEP);
	assign e_ovt   = evt & (mode_sel_in == MS_OVT);
	assign e_rst   = evt & (mode_sel_in == MS_RST);

	// operating state follows the accepted mode requests
	always_comb begin
		state_nxt = state_r;
		unique case (1'b1)
			e_stby:  state_nxt = ST_STBY;
			e_norm:  state_nxt = ST_NORM;
			e_sleep: state_nxt = ST_SLEEP;
			e_ovt:   state_nxt = ST_OVT;
			e_rst:   state_nxt = ST_RST;
			default: state_nxt = state_r;
		endcase
	end

	// power-on pending: the nvm-derived loads cannot sit on the reset
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r    <= ST_OFF;
			por_pend_r <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			por_pend_r <= 1'b0;
		end
	end
	assign mode_state_out = state_r;

	// ***************************************************
	// fields forced by mode transitions
	// ***************************************************
	// the fields below take per-field event strobes, period and cause sharing one; the threshold and supply fields take none
	// mode field codes per entered mode
	mrd_field #(.W(3), .RST(MC_STBY)) u_mc (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.por_ld_in  (por_pend_r),
		.por_val_in (MC_STBY),
		.evt_ld_in  (e_stby | e_norm | e_sleep | e_rst),
		.evt_val_in (e_norm ? MC_NORM : (e_sleep ? MC_SLEEP : MC_STBY)),
		.sw_we_in   (we_mode),
		.sw_val_in  (wd_r[2:0]),
		.q_out      (op_mode_ctrl_out)
	);

	// period reload on overtemp or reset only
	mrd_field #(.W(4), .RST(NWP_DFLT)) u_nwp (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.por_ld_in  (por_pend_r),
		.por_val_in (NWP_DFLT),
		.evt_ld_in  (e_ovt | e_rst),
		.evt_val_in (NWP_DFLT),
		.sw_we_in   (we_wdc),
		.sw_val_in  (wd_r[3:0]),
		.q_out      (wd_nominal_period_out)
	);

	// reset cause code, read-only to software
	mrd_field #(.W(5), .RST(RSS_PON)) u_rss (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.por_ld_in  (por_pend_r),
		.por_val_in (RSS_PON),
		.evt_ld_in  (e_ovt | e_rst),
		.evt_val_in (e_ovt ? RSS_OVT : reset_cause_in),
		.sw_we_in   (1'b0),
		.sw_val_in  (RSS_PON),
		.q_out      (rss_q)
	);

	// watchdog mode picked by sw-dev config
	mrd_field #(.W(3), .RST(WMC_DFLT)) u_wmc (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.por_ld_in  (por_pend_r),
		.por_val_in (sw_dev_config_in ? WMC_SWDEV : WMC_DFLT),
		.evt_ld_in  (e_rst),
		.evt_val_in (sw_dev_config_in ? WMC_SWDEV : WMC_DFLT),
		.sw_we_in   (we_wdc),
		.sw_val_in  (wd_r[P_WMC+:3]),
		.q_out      (wd_mode_ctrl_out)
	);

	// threshold and supply control from startup fields
	mrd_field #(.W(2), .RST(2'h0)) u_v1rt (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.por_ld_in  (por_pend_r),
		.por_val_in (reg_thresh_startup_in),
		.evt_ld_in  (1'b0),
		.evt_val_in (2'h0),
		.sw_we_in   (we_sup),
		.sw_val_in  (wd_r[1:0]),
		.q_out      (reg_thresh_ctrl_out)
	);

	mrd_field #(.W(2), .RST(2'h0)) u_vext (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.por_ld_in  (por_pend_r),
		.por_val_in (ext_supply_startup_in),
		.evt_ld_in  (1'b0),
		.evt_val_in (2'h0),
		.sw_we_in   (we_sup),
		.sw_val_in  (wd_r[P_EXTC+:2]),
		.q_out      (ext_supply_ctrl_out)
	);

	// ***************************************************
	// kept bits, status and event flags
	// ***************************************************
	always_comb begin
		// only a normal entry clears it
		nms_nxt  = e_norm ? 1'b0 : nms_r;
		// cleared in the power-on cycle, else live
		st_nxt   = por_pend_r ? 9'h000 : live_status_in;
		scr_nxt  = scr_r;
		if (we_scr) begin
			scr_nxt[8*(wr_idx-IX_SCR0)+:8] = wd_r;
		end
		lock_nxt = we_lock ? wd_r[6:0] : lock_r;
		en_nxt   = en_r;
		if (we_sev) begin
			en_nxt[2:1] = {wd_r[P_OTW], wd_r[P_SERIAL_FAIL_EVENT]};
		end
		if (we_trx) begin
			en_nxt[0] = wd_r[0];
		end
		// set wins over a write-one clear
		wdf_nxt  = wd_fail_in | (wdf_r & ~(we_sevt & wd_r[P_WDF]));
		serial_fail_event_nxt = (serial_fail_in & en_r[1])
			| (serial_fail_event_r & ~(we_sevt & wd_r[P_SERIAL_FAIL_EVENT]));
		otw_nxt  = (overtemp_warn_in & en_r[2])
			| (otw_r & ~(we_sevt & wd_r[P_OTW]));
		// set only by reset, cleared only by software
		po_nxt   = po_r & ~(we_sevt & wd_r[P_PO]);
		system_event_summary_nxt = wd_fail_in | (serial_fail_in & en_r[1])
			| (overtemp_warn_in & en_r[2])
			| (system_event_summary_r & ~(we_gevt & wd_r[P_SYSTEM_EVENT_SUMMARY]));
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			nms_r  <= 1'b1;
			st_r   <= 9'h000;
			scr_r  <= 32'h0000_0000;
			lock_r <= 7'h00;
			en_r   <= 3'h0;
			wdf_r  <= 1'b0;
			serial_fail_event_r <= 1'b0;
			otw_r  <= 1'b0;
			po_r   <= 1'b1;
			system_event_summary_r <= 1'b1;
		end else begin
			nms_r  <= nms_nxt;
			st_r   <= st_nxt;
			scr_r  <= scr_nxt;
			lock_r <= lock_nxt;
			en_r   <= en_nxt;
			wdf_r  <= wdf_nxt;
			serial_fail_event_r <= serial_fail_event_nxt;
			otw_r  <= otw_nxt;
			po_r   <= po_nxt;
			system_event_summary_r <= system_event_summary_nxt;
		end
	end
	assign can_wake_enable_out = en_r[0];

	// ***************************************************
	// register read map
	// ***************************************************
	function automatic logic mapped(input logic [6:0] ix);
		mapped = (ix <= IX_LOCK && ix != 7'h02) || ix == IX_SUPCTL
			|| ix == IX_SUPST || ix == IX_TRXST || ix == IX_TRXEN
			|| ix == IX_GEVT || ix == IX_SEVT || ix == IX_NVMST
			|| ix == IX_START || ix == IX_CFG || ix == IX_IDENT;
	endfunction : mapped

	assign rd_idx = s_araddr_in[8:2];
	assign rd_hit = mapped(rd_idx) && (s_araddr_in[AW-1:9] == '0);

	// config fields shown straight from the nvm inputs
	// nvm status shown live in every mode
	always_comb begin
		rd_byte = 8'h00;
		unique case (rd_idx)
			IX_WDCTRL: rd_byte = {wd_mode_ctrl_out, 1'b0,
				wd_nominal_period_out};
			IX_MODE:   rd_byte = {5'h00, op_mode_ctrl_out};
			IX_MSTAT:  rd_byte = {1'b0, st_r[1], nms_r, rss_q};
			IX_SEVEN:  rd_byte = {5'h00, en_r[2:1], 1'b0};
			IX_WDSTAT: rd_byte = {4'h0, st_r[0], st_r[2], st_r[6:5]};
			IX_LOCK:   rd_byte = {1'b0, lock_r};
			IX_SUPCTL: rd_byte = {4'h0, ext_supply_ctrl_out,
				reg_thresh_ctrl_out};
			IX_SUPST:  rd_byte = {5'h00, st_r[8:7], st_r[3]};
			IX_TRXST:  rd_byte = {6'h00, st_r[4], 1'b0};
			IX_TRXEN:  rd_byte = {7'h00, en_r[0]};
			IX_GEVT:   rd_byte = {7'h00, system_event_summary_r};
			IX_SEVT:   rd_byte = {3'h0, po_r, 1'b0, otw_r, serial_fail_event_r, wdf_r};
			IX_NVMST:  rd_byte = {nvm_write_count_status_in,
				nvm_checksum_status_in, nvm_programmed_status_in};
			IX_START:  rd_byte = {2'h0, reset_length_config_in,
				ext_supply_startup_in, 2'h0};
			IX_CFG:    rd_byte = {2'h0, reg_thresh_startup_in,
				forced_normal_config_in, sw_dev_config_in, 1'b0,
				sleep_ctrl_config_in};
			IX_IDENT:  rd_byte = PART_IDENT;
			default: begin
				if (rd_idx >= IX_SCR0 && rd_idx <= IX_SCR3) begin
					rd_byte = scr_r[8*(rd_idx-IX_SCR0)+:8];
				end
			end
		endcase
	end

	// ***************************************************
	// AXI4-Lite slave
	// ***************************************************
	assign wr_idx   = aw_addr_r[8:2];
	assign wr_go    = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_hit   = mapped(wr_idx) && (aw_addr_r[AW-1:9] == '0);
	assign lock_blk = (wr_idx[6:4] != 3'h0)
		&& lock_r[3'(wr_idx[6:4] - 3'h1)];
	// a write meeting a mode change or power-on is dropped
	assign commit   = wr_go & wr_hit & ~lock_blk & w_lane_r
		& ~mode_enter_in & ~por_pend_r;
	assign we_wdc   = commit & (wr_idx == IX_WDCTRL);
	assign we_mode  = commit & (wr_idx == IX_MODE);
	assign we_sev   = commit & (wr_idx == IX_SEVEN);
	assign we_lock  = commit & (wr_idx == IX_LOCK);
	assign we_sup   = commit & (wr_idx == IX_SUPCTL);
	assign we_trx   = commit & (wr_idx == IX_TRXEN);
	assign we_gevt  = commit & (wr_idx == IX_GEVT);
	assign we_sevt  = commit & (wr_idx == IX_SEVT);
	assign we_scr   = commit & (wr_idx >= IX_SCR0) & (wr_idx <= IX_SCR3);

	// address and data are taken in either order and held till used
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		aw_addr_nxt = aw_addr_r;
		wd_nxt      = wd_r;
		w_lane_nxt  = w_lane_r;
		bvalid_nxt  = bvalid_r & ~s_bready_in;
		bresp_nxt   = bresp_r;
		if (s_awvalid_in & ~aw_have_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_awaddr_in;
		end
		if (s_wvalid_in & ~w_have_r) begin
			w_have_nxt = 1'b1;
			wd_nxt     = s_wdata_in[7:0];
			w_lane_nxt = s_wstrb_in[0];
		end
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? RESP_OK : RESP_ERR;
		end
		rvalid_nxt = rvalid_r & ~s_rready_in;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_arvalid_in & ~rvalid_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			rresp_nxt  = rd_hit ? RESP_OK : RESP_ERR;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= '0;
			wd_r      <= 8'h00;
			w_lane_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OK;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= RESP_OK;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			wd_r      <= wd_nxt;
			w_lane_r  <= w_lane_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	assign s_awready_out = ~aw_have_r;
	assign s_wready_out  = ~w_have_r;
	assign s_bvalid_out  = bvalid_r;
	assign s_bresp_out   = bresp_r;
	assign s_arready_out = ~rvalid_r;
	assign s_rvalid_out  = rvalid_r;
	assign s_rdata_out   = rdata_r;
	assign s_rresp_out   = rresp_r;

	// ***************************************************
	// assertions
	// ***************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	mc_normal_a: assert property (
		e_norm |=> op_mode_ctrl_out == MC_NORM)
		else $error("mode field not 111 after normal entry");
	mc_keep_a: assert property (
		evt && !(e_stby || e_norm || e_sleep || e_rst)
		|=> $stable(op_mode_ctrl_out))
		else $error("mode field moved on an ignored mode code");
	nwp_reload_a: assert property (
		(e_ovt | e_rst) |=> wd_nominal_period_out == NWP_DFLT)
		else $error("period not reloaded");
	rss_ovt_a: assert property (
		e_ovt |=> rss_q == RSS_OVT ##1
		(rss_q == RSS_OVT || $past(e_rst)))
		else $error("reset cause not overtemp code");
	nms_clear_a: assert property ($fell(nms_r) |-> $past(e_norm))
		else $error("normal flag cleared without normal entry");
	po_keep_a: assert property (evt |=> $stable(po_r))
		else $error("power-on flag moved on mode change");
	wmc_reset_a: assert property (
		e_rst |=> wd_mode_ctrl_out ==
		($past(sw_dev_config_in) ? WMC_SWDEV : WMC_DFLT))
		else $error("watchdog mode wrong after reset entry");
	// the load edge is seen as the fall of the pending flag, so an
	// attempt at the release edge itself never looks at reset values
	thresh_por_a: assert property (
		$fell(por_pend_r) |->
		reg_thresh_ctrl_out == $past(reg_thresh_startup_in))
		else $error("threshold not loaded at power-on");
	live_track_a: assert property (
		!por_pend_r |=> st_r == $past(live_status_in))
		else $error("status not tracking live state");
	lock_keep_a: assert property (evt |=> $stable(lock_r))
		else $error("locks changed on mode change");
	drop_write_a: assert property (
		wr_go && evt |=> $stable(scr_r) && $stable(en_r) ##0 bvalid_r)
		else $error("write not dropped on mode change");

	cov_normal_c: cover property (e_norm ##1 e_sleep);
	cov_drop_c: cover property (wr_go && evt);
	cov_write_c: cover property (we_scr ##[1:4] rvalid_r);

endmodule : mrd_bank

//--- test/mrd_bank_tb.sv
// self-checking bench for the mode-dependent register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module mrd_bank_tb import mrd_pkg::*; ;
	// ***************************************************
	// stimulus and observed signals
	// ***************************************************
	logic        clk = 0, arst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic        men = 0, fnc = 0, sdc = 0, slc = 0, ecc = 0, prog = 0;
	logic        wd_fail_event = 0, spf = 0, overtemp_warn_event = 0;
	logic [11:0] awa = '0, ara = '0;
	logic [31:0] wda = '0;
	logic [2:0]  msel = '0;
	logic [4:0]  rcause = '0;
	logic [1:0]  reset_length_config = '0, rts = '0, ets = '0;
	logic [5:0]  wcnt = '0;
	logic [8:0]  live = '0;
	logic        awr, wr_r, bv, arr, rv, can_wake_enable;
	logic [1:0]  bresp, rresp, rtc, etc_o, r;
	logic [31:0] rdata, v;
	logic [5:0]  mstate;
	logic [2:0]  mc, wd_mode_ctrl, m_mc, m_wmc;
	logic [3:0]  wd_nominal_period, m_nwp;
	logic [4:0]  m_rss;
	logic [7:0]  m_scr, m_sevt, x;
	logic [6:0]  m_lk;
	logic [1:0]  m_rt, m_et;
	logic        m_nms;
	int          errors = 0, comparisons = 0, cycles = 0, seed = 32'h8277;
	logic [2:0]  codes [9] = '{MS_STBY, MS_SLEEP, MS_OVT, MS_RST, MS_NORM,
		MS_SLEEP, MS_RST, MS_OVT, MS_STBY};

	mrd_bank u_dut (.mclk_in(clk), .arst_n_in(arst), .s_awaddr_in(awa),
		.s_awvalid_in(awv), .s_awready_out(awr), .s_wdata_in(wda),
		.s_wstrb_in(4'hF), .s_wvalid_in(wv), .s_wready_out(wr_r),
		.s_bresp_out(bresp), .s_bvalid_out(bv), .s_bready_in(br),
		.s_araddr_in(ara), .s_arvalid_in(arv), .s_arready_out(arr),
		.s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rv),
		.s_rready_in(rr), .mode_enter_in(men), .mode_sel_in(msel),
		.reset_cause_in(rcause), .forced_normal_config_in(fnc),
		.reset_length_config_in(reset_length_config), .sw_dev_config_in(sdc),
		.sleep_ctrl_config_in(slc), .reg_thresh_startup_in(rts),
		.ext_supply_startup_in(ets), .nvm_checksum_status_in(ecc),
		.nvm_programmed_status_in(prog), .nvm_write_count_status_in(wcnt),
		.live_status_in(live), .wd_fail_in(wd_fail_event), .serial_fail_in(spf),
		.overtemp_warn_in(overtemp_warn_event), .mode_state_out(mstate),
		.op_mode_ctrl_out(mc), .wd_mode_ctrl_out(wd_mode_ctrl),
		.wd_nominal_period_out(wd_nominal_period), .reg_thresh_ctrl_out(rtc),
		.ext_supply_ctrl_out(etc_o), .can_wake_enable_out(can_wake_enable));

	// clock and hang guard; the ceiling is far above the few hundred used
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			stop_test();
		end
	end

	// ***************************************************
	// expectation functions and bus tasks
	// ***************************************************
	function automatic logic [2:0] wmc_of(input logic s);
		return s ? WMC_SWDEV : WMC_DFLT;
	endfunction : wmc_of

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [6:0] ix, input logic [7:0] d,
		output logic [1:0] rs);
		logic ad, wd;
		ad = 0;
		wd = 0;
		rs = 2'h3;
		@(posedge clk);
		awa <= {3'h0, ix, 2'h0};
		wda <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		// only the bench timeout ends a wait for the answer
		forever begin
			@(posedge clk);
			if (ad && wd && bv === 1'b1) begin
				rs = bresp;
				br <= 1'b0;
				break;
			end
			if (!ad && awr === 1'b1) begin
				ad = 1;
				awv <= 1'b0;
			end
			if (!wd && wr_r === 1'b1) begin
				wd = 1;
				wv <= 1'b0;
			end
		end
	endtask : wr

	task automatic rd(input logic [6:0] ix, output logic [31:0] d,
		output logic [1:0] rs);
		logic ad;
		ad = 0;
		rs = 2'h3;
		@(posedge clk);
		ara <= {3'h0, ix, 2'h0};
		arv <= 1'b1;
		rr <= 1'b1;
		forever begin
			@(posedge clk);
			if (ad && rv === 1'b1) begin
				d = rdata;
				rs = rresp;
				rr <= 1'b0;
				break;
			end
			if (!ad && arr === 1'b1) begin
				ad = 1;
				arv <= 1'b0;
			end
		end
	endtask : rd

	// model of one accepted mode entry
	task automatic step(input logic [2:0] c);
		case (c)
			MS_STBY: m_mc = MC_STBY;
			MS_NORM: begin
				m_mc = MC_NORM;
				m_nms = 1'b0;
			end
			MS_SLEEP: m_mc = MC_SLEEP;
			MS_OVT: begin
				m_nwp = NWP_DFLT;
				m_rss = RSS_OVT;
			end
			MS_RST: begin
				m_mc = MC_STBY;
				m_nwp = NWP_DFLT;
				m_rss = rcause;
				m_wmc = wmc_of(sdc);
			end
			default: ;
		endcase
	endtask : step

	// reset held four cycles, then the power-on load cycle passes
	task automatic do_reset();
		logic [6:0] ix [7] = '{IX_MSTAT, IX_SEVT, IX_GEVT, IX_SEVEN, IX_SCR0,
			IX_SCR3, IX_LOCK};
		logic [7:0] ex [7] = '{8'h20, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		arst <= 1'b0;
		live <= '0;
		repeat (4) @(posedge clk);
		arst <= 1'b1;
		@(posedge clk);
		#1;
		{m_mc, m_nwp, m_rss, m_nms} = {MC_STBY, NWP_DFLT, RSS_PON, 1'b1};
		{m_wmc, m_rt, m_et, m_scr, m_lk} = {wmc_of(sdc), rts, ets, 15'h0};
		m_sevt = 8'h10;
		`CHK("po_mode", MC_STBY, mc)
		`CHK("po_state", 6'h01, mstate)
		`CHK("po_period", NWP_DFLT, wd_nominal_period)
		`CHK("po_wd_mode", m_wmc, wd_mode_ctrl)
		`CHK("po_ctrl", {rts, ets}, {rtc, etc_o})
		`CHK("po_cwe", 1'b0, can_wake_enable)
		for (int i = 0; i < 7; i++) begin
			rd(ix[i], v, r);
			`CHK("po_reg", ex[i], v[7:0])
		end
	endtask : do_reset

	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		do_reset();
		$display("test 1 done");
		{live, wcnt, ecc, prog, fnc, reset_length_config, slc, rts, ets} <=
			25'($random(seed));
		repeat (3) @(posedge clk);
		rd(IX_WDSTAT, v, r);
		`CHK("wd_stat", {live[0], live[2], live[6:5]}, v[3:0])
		rd(IX_SUPST, v, r);
		`CHK("sup_stat", {live[8:7], live[3]}, v[2:0])
		rd(IX_TRXST, v, r);
		`CHK("volt_stat", live[4], v[1])
		rd(IX_MSTAT, v, r);
		`CHK("otw_stat", live[1], v[6])
		rd(IX_NVMST, v, r);
		`CHK("nvm_stat", {wcnt, ecc, prog}, v[7:0])
		rd(IX_START, v, r);
		`CHK("startup", {reset_length_config, ets}, v[5:2])
		rd(IX_CFG, v, r);
		`CHK("config", {rts, fnc, sdc, slc}, {v[5:2], v[0]})
		`CHK("ctrl_kept", {m_rt, m_et}, {rtc, etc_o})
		$display("test 2 done");
		// serial capture enabled, overtemp capture left off
		wr(IX_SEVEN, 8'h02, r);
		@(posedge clk);
		{wd_fail_event, spf, overtemp_warn_event} <= 3'h7;
		@(posedge clk);
		{wd_fail_event, spf, overtemp_warn_event} <= 3'h0;
		rd(IX_SEVT, v, r);
		`CHK("events", 8'h13, v[7:0])
		wr(IX_SEVT, 8'h13, r);
		wr(IX_GEVT, 8'h01, r);
		rd(IX_SEVT, v, r);
		`CHK("evt_clr", 8'h00, v[7:0])
		m_sevt = 8'h00;
		wr(IX_TRXEN, 8'h01, r);
		`CHK("cwe_set", 1'b1, can_wake_enable)
		m_scr = 8'($random(seed));
		m_lk = 7'($random(seed)) | 7'h01;
		wr(IX_SCR0, m_scr, r);
		wr(IX_LOCK, {1'b0, m_lk}, r);
		wr(IX_SUPCTL, ~{4'h0, m_et, m_rt}, r);
		`CHK("locked", {m_rt, m_et}, {rtc, etc_o})
		$display("test 3 done");
		foreach (codes[i]) begin
			x = 8'($random(seed));
			rcause <= x[4:0];
			{m_wmc, m_nwp} = {x[7:5], x[3:0]};
			wr(IX_WDCTRL, {m_wmc, 1'b0, m_nwp}, r);
			@(posedge clk);
			men <= 1'b1;
			msel <= codes[i];
			@(posedge clk);
			men <= 1'b0;
			#1;
			step(codes[i]);
			`CHK("op_mode", m_mc, mc)
			`CHK("period", m_nwp, wd_nominal_period)
			`CHK("wd_mode", m_wmc, wd_mode_ctrl)
			`CHK("state", 6'h01 << codes[i], mstate)
			`CHK("ctrl", {m_rt, m_et}, {rtc, etc_o})
			`CHK("cwe_kept", 1'b1, can_wake_enable)
			rd(IX_MSTAT, v, r);
			`CHK("nms_rss", {m_nms, m_rss}, v[5:0])
			rd(IX_SCR0, v, r);
			`CHK("scratch", m_scr, v[7:0])
			rd(IX_LOCK, v, r);
			`CHK("locks", m_lk, v[6:0])
			rd(IX_SEVT, v, r);
			`CHK("sys_evt", m_sevt, v[7:0])
		end
		$display("test 4 done");
		// a write whose commit edge meets a mode pulse is lost
		for (int k = 0; k < 2; k++) begin
			fork
				wr(IX_SCR0, ~m_scr, r);
				begin
					repeat (2) @(posedge clk);
					men <= 1'b1;
					msel <= k ? MS_SLEEP : 3'h0;
					@(posedge clk);
					men <= 1'b0;
				end
			join
			step(k ? MS_SLEEP : 3'h0);
			rd(IX_SCR0, v, r);
			`CHK("dropped", m_scr, v[7:0])
			`CHK("mode_kept", m_mc, mc)
		end
		rd(7'h02, v, r);
		`CHK("unmapped_rd", {RESP_ERR, 32'h0}, {r, v})
		wr(7'h02, 8'hFF, r);
		`CHK("unmapped_wr", RESP_ERR, r)
		$display("test 5 done");
		{sdc, rts, ets} <= {1'b1, 4'(~{rts, ets})};
		do_reset();
		$display("test 6 done");
		stop_test();
	end
endmodule : mrd_bank_tb
